// File: inc/ips_pkg.sv
package ips_pkg;

    // widths of the word and of the largest memory's address
    localparam int DW = 16;
    localparam int AW = 14;

    // sector geometry: 512 words, nine in-sector address bits
    localparam int SECTOR_WORDS = 512;
    localparam int SECTOR_BITS  = $clog2(SECTOR_WORDS);

    // special locations
    localparam logic [13:0] FILL_LO  = 14'h0001;  // octal 00001
    localparam logic [13:0] FILL_HI  = 14'h000F;  // octal 00017
    localparam logic [13:0] PF_VEC   = 14'h0030;  // octal 00060
    localparam logic [13:0] INT_LINK = 14'h0033;  // octal 00063

    // memory reference operation codes used by the sequencer
    localparam logic [3:0] OP_NONMR = 4'h0;  // not a memory reference class
    localparam logic [3:0] OP_JUMP  = 4'h1;
    localparam logic [3:0] OP_STORE = 4'h4;

    // apb register byte offsets
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_CMD    = 12'h004;
    localparam logic [11:0] REG_PC     = 12'h008;
    localparam logic [11:0] REG_PADDR  = 12'h00C;
    localparam logic [11:0] REG_PDATA  = 12'h010;
    localparam logic [11:0] REG_STATUS = 12'h014;
    localparam logic [11:0] REG_INSTR  = 12'h018;
    localparam logic [11:0] REG_OPLOC  = 12'h01C;

    // control register bit positions
    localparam int CTL_RUN    = 0;
    localparam int CTL_STEP   = 1;
    localparam int CTL_PERMIT = 2;
    localparam int CTL_PANEL  = 3;
    localparam logic [3:0] CTRL_RST = 4'h0;

    // command register bit positions (write-only pulses)
    localparam int CMD_START = 0;
    localparam int CMD_HALT  = 1;
    localparam int CMD_PRD   = 2;
    localparam int CMD_PWR   = 3;
    localparam int CMD_PINC  = 4;

    typedef enum logic [2:0] {
        PH_HALT, PH_FETCH, PH_IND, PH_OPER, PH_BREAK, PH_PANEL
    } ips_phase_t;

    // every view of an instruction word at once
    typedef struct packed {
        logic        ind;
        logic        idx;
        logic [3:0]  mr_op;
        logic        sector;
        logic [8:0]  off;
        logic [15:0] gen_op;
        logic [5:0]  io_op;
        logic [3:0]  io_fn;
        logic [5:0]  io_dev;
        logic [9:0]  sh_op;
        logic [5:0]  sh_cnt;
        logic        mem_ref;
    } ips_dec_t;

    typedef struct packed {
        logic        sign;
        logic [14:0] mag;
    } ips_dword_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [13:0] addr;
        logic [15:0] wdata;
    } ips_mem_t;

endpackage : ips_pkg

// File: core/ips_decode.sv
module ips_decode (
    // instruction and context
    input  logic [15:0]         instr,
    input  logic [13:0]         pc,
    input  logic [15:0]         xr,
    input  logic [15:0]         word,
    // decoded views
    output ips_pkg::ips_dec_t   dec,
    output logic [13:0]         prov_addr,
    output logic [13:0]         eff_addr,
    output logic [13:0]         ind_addr,
    output ips_pkg::ips_dword_t sp_word,
    output ips_pkg::ips_dword_t lo_word
);
    import ips_pkg::*;

    logic [15:0] idx_sum;
    logic [15:0] ind_sum;

    // field split, bit 1 being the msb
    always_comb begin
        dec.ind     = instr[15];
        dec.idx     = instr[14];
        dec.mr_op   = instr[13:10];
        dec.sector  = instr[9];
        dec.off     = instr[8:0];
        dec.gen_op  = instr;
        dec.io_op   = instr[15:10];
        dec.io_fn   = instr[9:6];
        dec.io_dev  = instr[5:0];
        dec.sh_op   = instr[15:6];
        dec.sh_cnt  = ~instr[5:0] + 6'h01;
        dec.mem_ref = instr[13:10] != OP_NONMR;
    end

    // sector zero or current sector from the counter's upper five bits
    assign prov_addr = {instr[9] ? pc[13:SECTOR_BITS] : 5'h00, instr[8:0]};

    // full 16-bit index add, carry above the 14 address bits dropped
    assign idx_sum  = {2'h0, prov_addr} + xr;
    assign eff_addr = instr[14] ? idx_sum[13:0] : prov_addr;

    // indirect word: flag, tag, then a 14-bit address
    assign ind_sum  = {2'h0, word[13:0]} + xr;
    assign ind_addr = word[14] ? ind_sum[13:0] : word[13:0];

    // single word and high word share a layout; low word has sign forced off
    assign sp_word = {word[15], word[14:0]};
    assign lo_word = {1'b0, word[14:0]};

endmodule : ips_decode

// File: core/ips_sequencer.sv
// The register addresses and register access over APB were chosen for this implementation.
module ips_sequencer (
    // clock and reset
    input  logic                ref_clk,
    input  logic                sys_rst,
    // apb slave
    input  logic                psel,
    input  logic                penable,
    input  logic                pwrite,
    input  logic [11:0]         paddr,
    input  logic [31:0]         pwdata,
    output logic [31:0]         prdata,
    output logic                pready,
    output logic                pslverr,
    // core memory
    output ips_pkg::ips_mem_t   mem_cmd,
    input  logic [15:0]         mem_rdata,
    input  logic                mem_ack,
    // datapath context
    input  logic [15:0]         index_reg,
    input  logic [15:0]         store_data,
    input  logic                shift_busy,
    // break and interrupt requests
    input  logic                clock_tick_break,
    input  logic                memory_increment_break,
    input  logic                multiplex_channel_break,
    input  logic                std_interrupt,
    input  logic                priority_interrupt,
    input  logic                power_fail_interrupt,
    // sequencer state out
    output ips_pkg::ips_phase_t phase,
    output ips_pkg::ips_dec_t   instr_fields,
    output ips_pkg::ips_dword_t operand_hi,
    output ips_pkg::ips_dword_t operand_lo,
    output logic [13:0]         operand_location,
    output logic                break_grant,
    output logic                int_taken
);
    import ips_pkg::*;

    ips_phase_t  phase_q;
    ips_phase_t  held_q;
    ips_phase_t  ret_q;
    ips_phase_t  seq_nxt;
    logic [13:0] pc_q;
    logic [15:0] ir_q;
    logic [13:0] loc_q;
    logic [15:0] opnd_q;
    logic [3:0]  ctrl_q;
    logic [13:0] paddr_q;
    logic [15:0] pdata_q;
    logic        pwr_q;
    logic        pinc_q;
    logic        int_q;
    logic [31:0] prdata_q;

    ips_dec_t    dec;
    ips_dword_t  sp_word;
    ips_dword_t  lo_word;
    logic [13:0] prov_addr;
    logic [13:0] eff_addr;
    logic [13:0] ind_addr;
    logic [15:0] cur_instr;

    logic        bus_wr;
    logic        bus_setup;
    logic        mapped;
    logic        start_c;
    logic        halt_c;
    logic        panel_go;
    logic        mem_phase;
    logic        done;
    logic        is_jump;
    logic        instr_end;
    logic        brk_any;
    logic        pf_take;
    logic        si_take;
    logic        in_fill;
    logic        want_we;

    // during fetch the word on the data lines is the new instruction
    assign cur_instr = (phase_q == PH_FETCH) ? mem_rdata : ir_q;

    ips_decode u_decode (
        .instr     (cur_instr),
        .pc        (pc_q),
        .xr        (index_reg),
        .word      (mem_rdata),
        .dec       (dec),
        .prov_addr (prov_addr),
        .eff_addr  (eff_addr),
        .ind_addr  (ind_addr),
        .sp_word   (sp_word),
        .lo_word   (lo_word)
    );

    // apb decode: zero wait states, unmapped offsets answer with an error
    assign bus_setup = psel && !penable;
    assign bus_wr    = psel && penable && pwrite;
    always_comb begin
        if (paddr == REG_CTRL || paddr == REG_CMD || paddr == REG_PC) begin
            mapped = 1'b1;
        end else if (paddr == REG_PADDR || paddr == REG_PDATA) begin
            mapped = 1'b1;
        end else if (paddr == REG_STATUS || paddr == REG_INSTR || paddr == REG_OPLOC) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = prdata_q;

    // command pulses; panel access acts only while halted, start resumes only while halted but sets run in any phase
    assign start_c  = bus_wr && paddr == REG_CMD && pwdata[CMD_START];
    assign halt_c   = bus_wr && paddr == REG_CMD && pwdata[CMD_HALT];
    assign panel_go = bus_wr && paddr == REG_CMD && ctrl_q[CTL_PANEL]
                      && (pwdata[CMD_PRD] || pwdata[CMD_PWR]);

    // memory handshake: request stands until the acknowledge
    assign mem_phase = phase_q == PH_FETCH || phase_q == PH_IND
                       || phase_q == PH_OPER || phase_q == PH_PANEL;
    assign done      = mem_phase && mem_ack;
    assign is_jump   = dec.mr_op == OP_JUMP;

    // next phase from the instruction, the indirect word's flag and shift_busy, events not yet applied
    always_comb begin
        case (phase_q)
            PH_FETCH: begin
                if (!dec.mem_ref) begin
                    seq_nxt = PH_FETCH;
                end else if (dec.ind) begin
                    seq_nxt = PH_IND;
                end else if (is_jump) begin
                    seq_nxt = PH_FETCH;
                end else begin
                    seq_nxt = PH_OPER;
                end
            end
            PH_IND: begin
                if (mem_rdata[15]) begin
                    seq_nxt = PH_IND;
                end else if (is_jump) begin
                    seq_nxt = PH_FETCH;
                end else begin
                    seq_nxt = PH_OPER;
                end
            end
            PH_OPER: begin
                // extended operand phases are counted outside
                seq_nxt = shift_busy ? PH_OPER : PH_FETCH;
            end
            default: begin
                seq_nxt = PH_FETCH;
            end
        endcase
    end

    // events are looked at only when a phase completes
    assign instr_end = done && phase_q != PH_PANEL && seq_nxt == PH_FETCH;
    assign brk_any   = done && phase_q != PH_PANEL
                       && (multiplex_channel_break
                       || (instr_end && (clock_tick_break || memory_increment_break)));
    assign pf_take   = instr_end && !brk_any && power_fail_interrupt;
    assign si_take   = instr_end && !brk_any && !power_fail_interrupt
                       && ctrl_q[CTL_PERMIT]
                       && (std_interrupt || priority_interrupt);

    // phase register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_q <= PH_HALT;
            held_q  <= PH_FETCH;
            ret_q   <= PH_FETCH;
        end else begin
            case (phase_q)
                PH_HALT: begin
                    if (start_c) begin
                        phase_q <= held_q;
                    end else if (panel_go) begin
                        phase_q <= PH_PANEL;
                    end
                end
                PH_BREAK: begin
                    phase_q <= ret_q;
                end
                PH_PANEL: begin
                    if (done) begin
                        phase_q <= PH_HALT;
                    end
                end
                default: begin
                    if (brk_any) begin
                        phase_q <= PH_BREAK;
                        ret_q   <= seq_nxt;
                    end else if (done && phase_q == PH_FETCH && ctrl_q[CTL_STEP]) begin
                        phase_q <= PH_HALT;
                        held_q  <= seq_nxt;
                    end else if (instr_end && !ctrl_q[CTL_RUN]) begin
                        phase_q <= PH_HALT;
                        held_q  <= PH_FETCH;
                    end else if (done) begin
                        phase_q <= seq_nxt;
                    end
                end
            endcase
        end
    end

    // instruction counter: a break leaves it alone, an interrupt loads it
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pc_q <= 14'h0000;
        end else begin
            if (done && phase_q == PH_FETCH) begin
                if (dec.mem_ref && !dec.ind && is_jump) begin
                    pc_q <= eff_addr;
                end else begin
                    pc_q <= pc_q + 14'h0001;
                end
            end
            if (done && phase_q == PH_IND && is_jump && !mem_rdata[15]) begin
                pc_q <= ind_addr;
            end
            if (pf_take) begin
                pc_q <= PF_VEC;
            end else if (si_take) begin
                pc_q <= INT_LINK;
            end
            if (bus_wr && paddr == REG_PC && phase_q == PH_HALT) begin
                pc_q <= pwdata[13:0];
            end
        end
    end

    // instruction and operand location, settled before the operand phase
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ir_q  <= 16'h0000;
            loc_q <= 14'h0000;
        end else if (done && phase_q == PH_FETCH) begin
            ir_q  <= mem_rdata;
            loc_q <= eff_addr;
        end else if (done && phase_q == PH_IND) begin
            loc_q <= ind_addr;
        end
    end

    // operand capture from each operand phase except a store
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            opnd_q <= 16'h0000;
        end else if (done && phase_q == PH_OPER && dec.mr_op != OP_STORE) begin
            opnd_q <= mem_rdata;
        end
    end

    // control register; a software write of permit overrides the interrupt clear
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= CTRL_RST;
        end else begin
            if (pf_take || si_take) begin
                ctrl_q[CTL_PERMIT] <= 1'b0;
            end
            if (halt_c) begin
                ctrl_q[CTL_RUN] <= 1'b0;
            end
            if (start_c) begin
                ctrl_q[CTL_RUN] <= 1'b1;
            end
            if (bus_wr && paddr == REG_CTRL) begin
                ctrl_q <= pwdata[3:0];
            end
        end
    end

    // panel access: address, data and mode of the pending cycle
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            paddr_q <= 14'h0000;
            pdata_q <= 16'h0000;
            pwr_q   <= 1'b0;
            pinc_q  <= 1'b0;
        end else if (phase_q == PH_PANEL) begin
            if (done) begin
                if (!pwr_q) begin
                    pdata_q <= mem_rdata;
                end
                if (pinc_q) begin
                    paddr_q <= paddr_q + 14'h0001;
                end
            end
        end else if (bus_wr && paddr == REG_PADDR) begin
            paddr_q <= pwdata[13:0];
        end else if (bus_wr && paddr == REG_PDATA) begin
            pdata_q <= pwdata[15:0];
        end else if (panel_go && phase_q == PH_HALT) begin
            pwr_q  <= pwdata[CMD_PWR];
            pinc_q <= pwdata[CMD_PINC];
        end
    end

    // memory command; fill locations are shielded outside panel cycles
    assign in_fill = mem_cmd.addr >= FILL_LO && mem_cmd.addr <= FILL_HI;
    assign want_we = (phase_q == PH_OPER && dec.mr_op == OP_STORE)
                     || (phase_q == PH_PANEL && pwr_q);
    always_comb begin
        mem_cmd.req = mem_phase;
        case (phase_q)
            PH_FETCH: mem_cmd.addr = pc_q;
            PH_PANEL: mem_cmd.addr = paddr_q;
            default:  mem_cmd.addr = loc_q;
        endcase
        mem_cmd.we    = want_we && (phase_q == PH_PANEL || !in_fill);
        mem_cmd.wdata = (phase_q == PH_PANEL) ? pdata_q : store_data;
    end

    // interrupt acknowledge pulse
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            int_q <= 1'b0;
        end else begin
            int_q <= pf_take || si_take;
        end
    end

    // read data latched in the setup cycle, stable through the access
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_q <= 32'h0000_0000;
        end else if (bus_setup) begin
            if (paddr == REG_CTRL) begin
                prdata_q <= {28'h000_0000, ctrl_q};
            end else if (paddr == REG_PC) begin
                prdata_q <= {18'h0_0000, pc_q};
            end else if (paddr == REG_PADDR) begin
                prdata_q <= {18'h0_0000, paddr_q};
            end else if (paddr == REG_PDATA) begin
                prdata_q <= {16'h0000, pdata_q};
            end else if (paddr == REG_STATUS) begin
                prdata_q <= {26'h000_0000, held_q, phase_q};
            end else if (paddr == REG_INSTR) begin
                prdata_q <= {16'h0000, ir_q};
            end else if (paddr == REG_OPLOC) begin
                prdata_q <= {18'h0_0000, loc_q};
            end else begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    assign phase            = phase_q;
    assign instr_fields     = dec;
    assign operand_hi       = {opnd_q[15], opnd_q[14:0]};
    assign operand_lo       = {1'b0, opnd_q[14:0]};
    assign operand_location = loc_q;
    assign break_grant      = phase_q == PH_BREAK;
    assign int_taken        = int_q;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    fill_protect_a: assert property (mem_cmd.we && phase_q != PH_PANEL |-> !in_fill)
        else $error("write reached a fill location outside panel mode");
    sector_addr_a: assert property (done && phase_q == PH_FETCH && dec.mem_ref && !dec.idx
        |=> loc_q == {$past(mem_rdata[9]) ? $past(pc_q[13:9]) : 5'h00, $past(mem_rdata[8:0])})
        else $error("provisional address formed wrongly");
    index_add_a: assert property (done && phase_q == PH_FETCH && dec.idx
        |=> loc_q == 14'($past(prov_addr) + $past(index_reg[13:0])))
        else $error("indexed address wrong");
    fetch_ind_a: assert property (done && phase_q == PH_FETCH && dec.mem_ref && dec.ind
        && !brk_any && !ctrl_q[CTL_STEP] |=> phase_q == PH_IND)
        else $error("indirect flag did not schedule an indirect phase");
    ind_chain_a: assert property (done && phase_q == PH_IND && mem_rdata[15] && !brk_any
        |=> phase_q == PH_IND ##0 loc_q == $past(ind_addr))
        else $error("indirect chain broken");
    jump_noop_a: assert property (done && phase_q == PH_FETCH && dec.mem_ref && !dec.ind
        && is_jump |=> phase_q != PH_OPER)
        else $error("jump entered an operand phase");
    oper_loc_a: assert property (phase_q == PH_OPER |-> mem_cmd.req && mem_cmd.addr == loc_q)
        else $error("operand phase off the settled location");
    break_pc_a: assert property (phase_q == PH_BREAK |=> pc_q == $past(pc_q))
        else $error("break altered the counter");
    pf_vec_a: assert property (instr_end && !brk_any && power_fail_interrupt
        |=> pc_q == PF_VEC && int_taken)
        else $error("power fail not vectored");
    step_halt_a: assert property (done && phase_q == PH_FETCH && ctrl_q[CTL_STEP] && !brk_any
        |=> phase_q == PH_HALT)
        else $error("step mode did not halt after fetch");

    ind_seen_c: cover property (phase_q == PH_IND ##1 phase_q == PH_IND);
    brk_seen_c: cover property (phase_q == PH_BREAK);
    panel_wr_c: cover property (phase_q == PH_PANEL && mem_cmd.we && mem_ack);
    int_seen_c: cover property (si_take);

endmodule : ips_sequencer

// File: verif/ips_mem_model.sv
module ips_mem_model (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    // memory port
    input  wire ips_pkg::ips_mem_t cmd,
    input  wire logic              stall,
    output logic [15:0]            rdata,
    output logic                   ack
);
    timeunit 1ns;
    timeprecision 1ps;
    import ips_pkg::*;
    logic [15:0] mem [0:16383];
    // answer one cycle late or later; the bench may preload words
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack <= 1'b0;
        end else begin
            ack <= cmd.req & ~ack & ~stall;
            if (cmd.req & ack & cmd.we) begin
                mem[cmd.addr] <= cmd.wdata;
            end
        end
    end
    // no stale word off the answer cycle
    assign rdata = ack ? mem[cmd.addr] : ~mem[cmd.addr];
endmodule : ips_mem_model

// File: verif/ips_sequencer_bench.sv
module ips_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ips_pkg::*;
    logic        ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic        mem_ack, stall, break_grant, int_taken, vec_due;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [15:0] mem_rdata, index_reg, lfsr;
    logic [5:0]  rq;
    ips_mem_t    mem_cmd;
    ips_phase_t  phase;
    int          fails, samples_checked, n_int, n_brk;
    logic [14:0] q_mem [$];
    logic [13:0] q_int [$];
    // expected {we, addr} of each completed memory cycle
    logic [14:0] seq [12] = '{15'h0200, 15'h0215, 15'h0201, 15'h0020, 15'h0040, 15'h0123,
                              15'h0202, 15'h0150, 15'h0005, 15'h0151, 15'h4070, 15'h0152};
    ips_sequencer dut (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .mem_cmd, .mem_rdata, .mem_ack, .index_reg, .store_data(lfsr),
        .shift_busy(1'b0), .clock_tick_break(rq[0]), .memory_increment_break(rq[1]),
        .multiplex_channel_break(rq[2]), .std_interrupt(rq[3]), .priority_interrupt(rq[4]),
        .power_fail_interrupt(rq[5]), .phase, .instr_fields(), .operand_hi(), .operand_lo(),
        .operand_location(), .break_grant, .int_taken);
    ips_mem_model mem_u (.ref_clk, .sys_rst, .cmd(mem_cmd), .stall, .rdata(mem_rdata), .ack(mem_ack));
    // free-running clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next
    // random stalls from the memory side
    always @(posedge ref_clk) begin
        lfsr <= lfsr_next(lfsr);
        stall <= lfsr[0] & lfsr[3];
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test;
        $display("counts: %0d checked, %0d mismatches", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    // one apb transfer, entered just after an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic err);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        err = pslverr;
        rdat = prdata;
        if (n >= 50) fails++;
        if (n >= 50) stop_test();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb
    // wait until every noted result has been seen
    task automatic settle(input int k);
        int n;
        for (n = 0; (q_mem.size() > 0 || q_int.size() > 0 || n_int < k) && n < 2000; n++) @(posedge ref_clk);
        if (n >= 2000) fails++;
        if (n >= 2000) stop_test();
    endtask : settle
    // watcher: pops the oldest note whenever a memory cycle completes
    always @(posedge ref_clk) begin
        if (int_taken === 1'b1) vec_due = 1'b1;
        if (int_taken === 1'b1) n_int++;
        if (break_grant === 1'b1) n_brk++;
        if (mem_cmd.req === 1'b1 && mem_ack === 1'b1) begin
            if (vec_due && phase === PH_FETCH && q_int.size() > 0) begin
                vec_due = 1'b0;
                check({2'b00, mem_cmd.addr}, {2'b00, q_int.pop_front()});
            end else if (q_mem.size() > 0) begin
                check({1'b0, mem_cmd.we, mem_cmd.addr}, {1'b0, q_mem.pop_front()});
            end
        end
    end
    // main sequence
    initial begin
        logic e;
        {sys_rst, psel, penable, pwrite, paddr, pwdata, rq, stall} = {1'b1, 54'h0};
        {lfsr, index_reg, fails, samples_checked, n_int, n_brk, vec_due} = {16'h0031, 16'h4005, 129'h0};
        for (int i = 0; i < 16384; i++) mem_u.mem[i] = 16'h0000;
        {mem_u.mem[14'h0200], mem_u.mem[14'h0201], mem_u.mem[14'h0202]} = 48'h4A10_8820_0550;
        {mem_u.mem[14'h0020], mem_u.mem[14'h0040]} = 32'h8040_0123;
        {mem_u.mem[14'h0150], mem_u.mem[14'h0151]} = 32'h1005_1070;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        check({13'h0, phase}, {13'h0, PH_HALT});
        apb(1'b0, 12'h020, 32'h0, e);
        check({15'h0, e}, 16'h0001);
        foreach (seq[i]) q_mem.push_back(seq[i]);
        apb(1'b1, REG_PC, 32'h0000_0200, e);
        apb(1'b0, REG_PC, 32'h0000_0000, e);
        check(rdat[15:0], 16'h0200);
        apb(1'b1, REG_CTRL, 32'h0000_0001, e);
        apb(1'b1, REG_CMD, 32'h0000_0001, e);
        settle(0);
        check(mem_u.mem[14'h0005], 16'h0000);
        $display("program sequence done");
        q_int.push_back(PF_VEC);
        rq[5] <= 1'b1;
        // drop the level as soon as it is taken, before the vector fetch ends
        for (int n = 0; int_taken !== 1'b1 && n < 2000; n++) @(posedge ref_clk);
        rq[5] <= 1'b0;
        settle(1);
        rq[3] <= 1'b1;
        repeat (40) @(posedge ref_clk);
        check(n_int[15:0], 16'h0001);
        q_int.push_back(INT_LINK);
        apb(1'b1, REG_CTRL, 32'h0000_0005, e);
        settle(2);
        rq[3] <= 1'b0;
        $display("interrupt test done");
        rq[2:0] <= 3'b111;
        for (int n = 0; n_brk < 3 && n < 500; n++) @(posedge ref_clk);
        rq[2:0] <= 3'b000;
        check({15'h0, n_brk >= 3}, 16'h0001);
        check(n_int[15:0], 16'h0002);
        $display("break test done");
        stop_test();
    end
endmodule : ips_sequencer_bench
